// *** hw/aeb_pkg.sv ***
// aeb_pkg: operation codes, request and result carriers, flag layout,
// cycle counts and register offsets for the execute unit.
// assumes the fetch stage decodes instructions into aeb_op_t codes.
package aeb_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_CARRY, OP_ADD_IMM_WORD, OP_SUB, OP_SUBTRACT_IMM,
    OP_SUBTRACT_CARRY_OP, OP_SUBTRACT_CARRY_IMM, OP_SUBTRACT_IMM_WORD,
    OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_INVERT, OP_ARITH_INVERSE,
    OP_SET_BITS, OP_CLEAR_BITS, OP_INC, OP_MINUS_ONE, OP_ZERO_MINUS_TEST,
    OP_ZERO_REGISTER, OP_ALL_ONES, OP_REL_JUMP, OP_IND_JUMP, OP_REL_SUBCALL,
    OP_IND_SUBCALL, OP_SUB_EXIT, OP_INT_EXIT, OP_EQUAL_SKIP, OP_COMPARE,
    OP_COMPARE_CARRY, OP_COMPARE_IMM, OP_SKIP_REG_CLR, OP_SKIP_REG_SET,
    OP_SKIP_IO_CLR, OP_SKIP_IO_SET, OP_BRANCH_SET, OP_BRANCH_CLR, OP_BRANCH_EQ
  } aeb_op_t;

  // operands are register values already read from the working file;
  // for word ops a is the low register and b the high register
  typedef struct packed {
    aeb_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] imm;
    logic [11:0] offset;
    logic [15:0] pc;
    logic [15:0] ptr;
    logic [15:0] stack_pc;
    logic [2:0] bit_sel;
    logic [7:0] io_val;
    logic next_two_word;
  } aeb_req_t;

  typedef struct packed {
    logic wr_en;
    logic wr_word;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic [15:0] pc_next;
  } aeb_res_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic h;
    logic v;
  } aeb_arith_t;

  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_MAX_POS = 8'h7F;
  localparam logic [7:0] BYTE_MIN_NEG = 8'h80;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [15:0] PC_SKIP_LONG = 16'h0003;

  localparam logic [1:0] OFS_FLAGS = 2'h0;
  localparam logic [1:0] OFS_STATUS = 2'h1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_CYC_LO = 1;
  localparam int STAT_CYC_HI = 3;

  localparam logic [7:0] FLAGS_RST = 8'h00;

endpackage : aeb_pkg

// *** hw/aeb_execute.sv ***
// aeb_execute: arithmetic, logic, compare, skip, jump, call/return and
// branch execution for an 8-bit core, with its own flag register.
// assumes the fetch stage presents one decoded request at a time, waits
// while o_busy is high, and writes o_res back into the working registers.
// Functional notes
// - add and add-carry: sum, one cycle, ZCNVH
// - word immediate add: two cycles, ZCNVS, no H
// - word immediate subtract: two cycles, ZCNVS
// - subtract register or constant: one cycle, ZCNVH
// - subtract with carry: one cycle, ZCNVH
// - and/or/xor: one cycle, ZNV, keep C,H
// - invert: 0xFF minus value, ZCNV
// - arithmetic inverse: 0x00 minus value, ZCNVH
// - set/clear bits by mask, one cycle, ZNV
// - increment/decrement: one cycle, ZNV, keep carry
// - zero-minus test: and with itself, ZNV
// - zero register via xor; all-ones keeps flags
// - relative/indirect jump: two cycles, no flags
// - calls three cycles; returns four; interrupt exit sets I
// - equal skip: skip next when equal, no flags
// - compares: difference not stored, ZNVCH, one cycle
// - skip on register bit clear or set
// - skip on I/O bit clear or set
// - flag branches add offset plus one when taken
`timescale 1ns/10ps
module aeb_execute
  import aeb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire aeb_req_t i_req,
  output aeb_res_t o_res,
  output logic o_done,
  output logic o_busy,
  output logic [7:0] o_flags,
  input wire logic [1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata
);

  function automatic aeb_arith_t aeb_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [8:0] s;
    logic [4:0] hs;
    aeb_arith_t r;
    s = {1'h0, a} + {1'h0, b} + {8'h00, cin};
    hs = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
    r.res = s[7:0];
    r.c = s[8];
    r.h = hs[4];
    r.v = (a[7] == b[7]) && (s[7] != a[7]);
    return r;
  endfunction : aeb_add

  function automatic aeb_arith_t aeb_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [8:0] d;
    logic [4:0] hd;
    aeb_arith_t r;
    d = {1'h0, a} - {1'h0, b} - {8'h00, cin};
    hd = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, cin};
    r.res = d[7:0];
    r.c = d[8];
    r.h = hd[4];
    r.v = (a[7] != b[7]) && (d[7] != a[7]);
    return r;
  endfunction : aeb_sub

  // Z, N, V and S follow the result; the signed flag is always N xor V
  function automatic logic [7:0] aeb_znv(input logic [7:0] f, input logic [7:0] r,
                                         input logic v);
    logic [7:0] n;
    n = f;
    n[FLAG_Z] = (r == BYTE_ZERO);
    n[FLAG_N] = r[7];
    n[FLAG_V] = v;
    n[FLAG_S] = r[7] ^ v;
    return n;
  endfunction : aeb_znv

  function automatic logic [7:0] aeb_arith_flags(input logic [7:0] f, input aeb_arith_t r);
    logic [7:0] n;
    n = aeb_znv(f, r.res, r.v);
    n[FLAG_C] = r.c;
    n[FLAG_H] = r.h;
    return n;
  endfunction : aeb_arith_flags

  wire logic [7:0] flags = o_flags;
  logic [2:0] cnt;
  logic [2:0] last_cyc;
  aeb_res_t next_res;
  logic [7:0] next_flags;
  logic [2:0] next_cyc;

  wire logic accept = i_req_valid && !o_busy;
  wire logic cin = flags[FLAG_C];
  // one shared subtractor serves subtract and compare; carry-in only for carry variants
  wire logic add_cin = (i_req.op == OP_ADD_CARRY) && cin;
  wire logic sub_cin = cin && (i_req.op inside {OP_SUBTRACT_CARRY_OP, OP_SUBTRACT_CARRY_IMM,
                                                OP_COMPARE_CARRY});
  wire logic sub_imm = i_req.op inside {OP_SUBTRACT_IMM, OP_SUBTRACT_CARRY_IMM, OP_COMPARE_IMM};
  wire logic [7:0] sub_opnd = sub_imm ? i_req.imm : i_req.b;
  wire aeb_arith_t add_sel = aeb_add(i_req.a, i_req.b, add_cin);
  wire aeb_arith_t sub_sel = aeb_sub(i_req.a, sub_opnd, sub_cin);
  wire aeb_arith_t arith_inv_r = aeb_sub(BYTE_ZERO, i_req.a, 1'h0);
  wire logic [7:0] inc_r = i_req.a + BYTE_ONE;
  wire logic [7:0] minus_one_r = i_req.a - BYTE_ONE;
  wire logic [7:0] inv_r = BYTE_ONES - i_req.a;

  wire logic [15:0] word_in = {i_req.b, i_req.a};
  wire logic [16:0] word_add = {1'h0, word_in} + {9'h000, i_req.imm};
  wire logic [16:0] word_sub = {1'h0, word_in} - {9'h000, i_req.imm};

  wire logic [15:0] pc_seq = i_req.pc + PC_STEP;
  wire logic [15:0] pc_rel = i_req.pc + {{4{i_req.offset[11]}}, i_req.offset} + PC_STEP;
  wire logic [15:0] pc_skip = i_req.pc + (i_req.next_two_word ? PC_SKIP_LONG : PC_SKIP_SHORT);
  wire logic [2:0] cyc_skip = i_req.next_two_word ? CYC_THREE : CYC_TWO;
  wire logic reg_bit = i_req.b[i_req.bit_sel];
  wire logic io_bit = i_req.io_val[i_req.bit_sel];
  wire logic flag_bit = flags[i_req.bit_sel];

  wire logic [7:0] status_val = {4'h0, last_cyc, o_busy};
  wire logic [7:0] rd_mux = (i_reg_addr == OFS_FLAGS) ? flags :
                            (i_reg_addr == OFS_STATUS) ? status_val : BYTE_ZERO;

  always_comb
  begin
    next_flags = flags;
    next_res.wr_en = 1'h0;
    next_res.wr_word = 1'h0;
    next_res.res_lo = i_req.a;
    next_res.res_hi = i_req.b;
    next_res.pc_next = pc_seq;
    next_cyc = CYC_ONE;
    unique case (i_req.op)
      OP_NOP:
      begin
      end
      OP_ADD, OP_ADD_CARRY:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = add_sel.res;
        next_flags = aeb_arith_flags(flags, add_sel);
      end
      OP_ADD_IMM_WORD:
      begin
        next_res.wr_en = 1'h1;
        next_res.wr_word = 1'h1;
        {next_res.res_hi, next_res.res_lo} = word_add[15:0];
        next_cyc = CYC_TWO;
        next_flags[FLAG_C] = word_add[16];
        next_flags[FLAG_Z] = (word_add[15:0] == {BYTE_ZERO, BYTE_ZERO});
        next_flags[FLAG_N] = word_add[15];
        next_flags[FLAG_V] = !word_in[15] && word_add[15];
        next_flags[FLAG_S] = word_add[15] ^ (!word_in[15] && word_add[15]);
      end
      OP_SUBTRACT_IMM_WORD:
      begin
        next_res.wr_en = 1'h1;
        next_res.wr_word = 1'h1;
        {next_res.res_hi, next_res.res_lo} = word_sub[15:0];
        next_cyc = CYC_TWO;
        next_flags[FLAG_C] = word_sub[16];
        next_flags[FLAG_Z] = (word_sub[15:0] == {BYTE_ZERO, BYTE_ZERO});
        next_flags[FLAG_N] = word_sub[15];
        next_flags[FLAG_V] = word_in[15] && !word_sub[15];
        next_flags[FLAG_S] = word_sub[15] ^ (word_in[15] && !word_sub[15]);
      end
      OP_SUB, OP_SUBTRACT_IMM, OP_SUBTRACT_CARRY_OP, OP_SUBTRACT_CARRY_IMM:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = sub_sel.res;
        next_flags = aeb_arith_flags(flags, sub_sel);
      end
      OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR:
      begin
        next_res.wr_en = 1'h1;
        unique case (i_req.op)
          OP_AND: next_res.res_lo = i_req.a & i_req.b;
          OP_AND_IMM: next_res.res_lo = i_req.a & i_req.imm;
          OP_OR: next_res.res_lo = i_req.a | i_req.b;
          OP_OR_IMM: next_res.res_lo = i_req.a | i_req.imm;
          default: next_res.res_lo = i_req.a ^ i_req.b;
        endcase
        next_flags = aeb_znv(flags, next_res.res_lo, 1'h0);
      end
      OP_INVERT:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = inv_r;
        next_flags = aeb_znv(flags, inv_r, 1'h0);
        next_flags[FLAG_C] = 1'h1;
      end
      OP_ARITH_INVERSE:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = arith_inv_r.res;
        next_flags = aeb_arith_flags(flags, arith_inv_r);
      end
      OP_SET_BITS, OP_CLEAR_BITS:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = (i_req.op == OP_SET_BITS) ? (i_req.a | i_req.imm) :
                          (i_req.a & (BYTE_ONES - i_req.imm));
        next_flags = aeb_znv(flags, next_res.res_lo, 1'h0);
      end
      OP_INC:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = inc_r;
        next_flags = aeb_znv(flags, inc_r, i_req.a == BYTE_MAX_POS);
      end
      OP_MINUS_ONE:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = minus_one_r;
        next_flags = aeb_znv(flags, minus_one_r, i_req.a == BYTE_MIN_NEG);
      end
      OP_ZERO_MINUS_TEST:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = i_req.a & i_req.a;
        next_flags = aeb_znv(flags, i_req.a, 1'h0);
      end
      OP_ZERO_REGISTER:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = i_req.a ^ i_req.a;
        next_flags = aeb_znv(flags, BYTE_ZERO, 1'h0);
      end
      OP_ALL_ONES:
      begin
        next_res.wr_en = 1'h1;
        next_res.res_lo = BYTE_ONES;
      end
      OP_REL_JUMP, OP_IND_JUMP:
      begin
        next_res.pc_next = (i_req.op == OP_REL_JUMP) ? pc_rel : i_req.ptr;
        next_cyc = CYC_TWO;
      end
      OP_REL_SUBCALL, OP_IND_SUBCALL:
      begin
        next_res.pc_next = (i_req.op == OP_REL_SUBCALL) ? pc_rel : i_req.ptr;
        next_cyc = CYC_THREE;
      end
      OP_SUB_EXIT, OP_INT_EXIT:
      begin
        next_res.pc_next = i_req.stack_pc;
        next_cyc = CYC_FOUR;
        if (i_req.op == OP_INT_EXIT)
          next_flags[FLAG_I] = 1'h1;
      end
      OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM:
        next_flags = aeb_arith_flags(flags, sub_sel);
      OP_EQUAL_SKIP, OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET:
      begin
        if ((i_req.op == OP_EQUAL_SKIP && i_req.a == i_req.b) ||
            (i_req.op == OP_SKIP_REG_CLR && !reg_bit) ||
            (i_req.op == OP_SKIP_REG_SET && reg_bit) ||
            (i_req.op == OP_SKIP_IO_CLR && !io_bit) ||
            (i_req.op == OP_SKIP_IO_SET && io_bit))
        begin
          next_res.pc_next = pc_skip;
          next_cyc = cyc_skip;
        end
      end
      OP_BRANCH_SET, OP_BRANCH_CLR, OP_BRANCH_EQ:
      begin
        if ((i_req.op == OP_BRANCH_SET && flag_bit) ||
            (i_req.op == OP_BRANCH_CLR && !flag_bit) ||
            (i_req.op == OP_BRANCH_EQ && flags[FLAG_Z]))
        begin
          next_res.pc_next = pc_rel;
          next_cyc = CYC_TWO;
        end
      end
      // codes past the last op, such as a released request, act as a no-op
      default:
        next_res.wr_en = 1'h0;
    endcase
  end

  // multi-cycle ops hold o_busy; o_done marks the cycle the op completes
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cnt <= 3'h0;
      o_done <= 1'h0;
      o_busy <= 1'h0;
      last_cyc <= 3'h0;
      o_res <= '0;
    end
    else
    begin
      cnt <= accept ? next_cyc - CYC_ONE : (cnt != 3'h0 ? cnt - CYC_ONE : cnt);
      o_busy <= accept ? (next_cyc != CYC_ONE) : (cnt > CYC_ONE);
      o_done <= accept ? (next_cyc == CYC_ONE) : (cnt == CYC_ONE);
      if (accept)
      begin
        last_cyc <= next_cyc;
        o_res <= next_res;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_reg_rdata <= BYTE_ZERO;
    else
      o_reg_rdata <= i_reg_rd ? rd_mux : BYTE_ZERO;
  end

  // an accepted instruction owns the flags in its cycle; a software write
  // in the same cycle is dropped so flag updates stay in program order
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_flags <= FLAGS_RST;
    else if (accept)
      o_flags <= next_flags;
    else if (i_reg_wr && i_reg_addr == OFS_FLAGS)
      o_flags <= i_reg_wdata;
  end

  AST_ADD_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_ADD |=> o_done && o_res.wr_en &&
      o_res.res_lo == $past(i_req.a) + $past(i_req.b))
    else $error("add did not finish in one cycle with its sum");

  AST_WORD_ADD_TWO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_ADD_IMM_WORD |=> !o_done && o_busy ##1 o_done && !o_busy)
    else $error("word add did not take two cycles");

  AST_WORD_SUB_NO_H: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_SUBTRACT_IMM_WORD |=>
      o_flags[FLAG_H] == $past(o_flags[FLAG_H]) &&
      o_flags[FLAG_S] == (o_flags[FLAG_N] ^ o_flags[FLAG_V]))
    else $error("word subtract disturbed half carry or sign");

  AST_SUB_BORROW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_SUB |=>
      o_flags[FLAG_C] == ($past(i_req.a) < $past(i_req.b)))
    else $error("subtract carry does not show the borrow");

  AST_LOGIC_KEEPS_C: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && (i_req.op == OP_AND || i_req.op == OP_OR || i_req.op == OP_XOR) |=>
      $stable(o_flags[FLAG_C]) && $stable(o_flags[FLAG_H]) && !o_flags[FLAG_V])
    else $error("logic op changed carry or half carry");

  AST_INVERT_CARRY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_INVERT |=>
      o_flags[FLAG_C] && o_res.res_lo == ~$past(i_req.a))
    else $error("invert result or carry wrong");

  AST_INC_KEEPS_C: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && (i_req.op == OP_INC || i_req.op == OP_MINUS_ONE) |=> $stable(o_flags[FLAG_C]))
    else $error("increment or decrement changed carry");

  AST_ONES_NO_FLAGS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_ALL_ONES |=> $stable(o_flags) && o_res.res_lo == BYTE_ONES)
    else $error("all-ones load changed flags");

  AST_CALL_THREE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && (i_req.op == OP_REL_SUBCALL || i_req.op == OP_IND_SUBCALL) |=>
      !o_done [*2] ##1 o_done)
    else $error("call did not take three cycles");

  AST_EXIT_FOUR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_INT_EXIT |=>
      o_flags[FLAG_I] && o_res.pc_next == $past(i_req.stack_pc) ##0 !o_done [*3] ##1 o_done)
    else $error("interrupt exit wrong timing or enable");

  AST_NO_SKIP_ONE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_EQUAL_SKIP && i_req.a != i_req.b |=>
      o_done && o_res.pc_next == $past(i_req.pc) + PC_STEP)
    else $error("equal skip without match took more than one cycle");

  AST_BRANCH_TAKEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    accept && i_req.op == OP_BRANCH_EQ && flags[FLAG_Z] |=>
      o_res.pc_next == $past(pc_rel) && !o_done ##1 o_done)
    else $error("taken branch target or timing wrong");

endmodule : aeb_execute

// *** sim/aeb_fetch_model.sv ***
// aeb_fetch_model: stands in for the fetch stage, offering one decoded
// request at a time and counting cycles until the execute unit answers.
// assumes the bench calls issue only after the previous op has finished.
`timescale 1ns/10ps
module aeb_fetch_model
  import aeb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_done,
  output logic o_req_valid,
  output aeb_req_t o_req
);

  initial
  begin
    o_req_valid = 1'h0;
    o_req = '0;
  end

  // a released request shows inverted content, so late sampling is caught;
  // with dup the request stays up into the busy cycle and must be refused
  task automatic issue(input aeb_req_t r, input logic dup, output logic [15:0] n);
    int k;
    @(posedge i_clk);
    o_req_valid <= 1'h1;
    o_req <= r;
    @(posedge i_clk);
    o_req_valid <= dup;
    o_req <= ~r;
    n = 16'h0001;
    for (k = 0; k < 8; k++)
    begin
      #1;
      if (i_done === 1'h1)
        break;
      @(posedge i_clk);
      o_req_valid <= 1'h0;
      n = n + 16'h0001;
    end
    // look once the last edge has settled, not in its own time step
    #1;
    if (i_done !== 1'h1)
      n = 16'h0000;
  endtask : issue

endmodule : aeb_fetch_model

// *** sim/testbench.sv ***
// testbench: drives the execute unit through the fetch model and the
// register port, checking results, flags, cycle counts and next pc.
// assumes one 20 MHz clock and the package's op codes and offsets.
`timescale 1ns/10ps
module testbench
  import aeb_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic req_valid;
  logic done;
  logic busy;
  logic dp = 1'h0;
  logic [7:0] flags;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [15:0] n;
  aeb_req_t req;
  aeb_req_t q;
  aeb_res_t res;
  int error_cnt = 0;
  int checked = 0;
  int k;

  always #25 i_clk = ~i_clk;

  aeb_execute uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_valid(req_valid), .i_req(req),
    .o_res(res), .o_done(done), .o_busy(busy), .o_flags(flags), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata)
  );
  aeb_fetch_model fetch (
    .i_clk(i_clk), .i_done(done), .o_req_valid(req_valid), .o_req(req)
  );

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask : reg_rd

  function automatic aeb_req_t base(input aeb_op_t op);
    aeb_req_t r;
    r = '0;
    r.op = op;
    r.pc = 16'h0100;
    return r;
  endfunction : base

  // flags are preset first so that kept bits can be told from updated ones
  task automatic go(input logic [7:0] pre, input logic [2:0] cyc, input logic [7:0] fl);
    reg_wr(OFS_FLAGS, pre);
    fetch.issue(q, dp, n);
    if (n === 16'h0000)
    begin
      error_cnt++;
      tally_and_finish();
    end
    chk("cycles", {13'h0, cyc}, n);
    chk("flags", {8'h00, fl}, {8'h00, flags});
  endtask : go

  // b feeds both the source register and the constant; each op uses one
  task automatic alu(input aeb_op_t op, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] pre, input logic [7:0] lo, input logic [7:0] fl);
    logic st;
    st = !(op inside {OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM});
    q = base(op);
    q.a = a;
    q.b = b;
    q.imm = b;
    go(pre, 3'h1, fl);
    chk("wr_en", {15'h0, st}, {15'h0, res.wr_en});
    if (st)
      chk("res_lo", {8'h00, lo}, {8'h00, res.res_lo});
  endtask : alu

  task automatic flow(input logic [7:0] pre, input logic [2:0] cyc, input logic [15:0] pc);
    go(pre, cyc, (q.op == OP_INT_EXIT) ? (pre | 8'h80) : pre);
    chk("pc_next", pc, res.pc_next);
  endtask : flow

  task automatic skp(input aeb_op_t op, input logic [7:0] w, input logic [2:0] bs,
    input logic two, input logic [2:0] cyc, input logic [15:0] pc);
    q = base(op);
    q.a = 8'h33;
    q.b = w;
    q.io_val = w;
    q.bit_sel = bs;
    q.next_two_word = two;
    flow(8'h5A, cyc, pc);
  endtask : skp

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_clk);
    #1;
    chk("reset flags", 16'h0000, {8'h00, flags});
    chk("reset done busy", 16'h0000, {14'h0, done, busy});
    chk("reset pc_next", 16'h0000, res.pc_next);
    reg_wr(OFS_FLAGS, 8'hA5);
    reg_rd(OFS_FLAGS, v);
    chk("flags read", 16'h00A5, {8'h00, v});
    @(posedge i_clk);
    #1;
    chk("rdata idle", 16'h0000, {8'h00, rdata});
    reg_rd(2'h3, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    alu(OP_ADD,8'h7F,8'h01,8'hC0,8'h80,8'hEC);
    alu(OP_ADD_CARRY,8'hFF,8'h00,8'h01,8'h00,8'h23);
    alu(OP_SUB,8'h80,8'h01,8'h00,8'h7F,8'h38);
    alu(OP_SUBTRACT_IMM,8'h01,8'h02,8'h00,8'hFF,8'h35);
    alu(OP_SUBTRACT_CARRY_OP,8'h05,8'h05,8'h01,8'hFF,8'h35);
    alu(OP_SUBTRACT_CARRY_IMM,8'h10,8'h0F,8'h01,8'h00,8'h22);
    alu(OP_AND,8'hF0,8'h8F,8'h21,8'h80,8'h35);
    alu(OP_AND_IMM,8'h0F,8'hF0,8'h21,8'h00,8'h23);
    alu(OP_OR,8'h80,8'h01,8'h08,8'h81,8'h14);
    alu(OP_OR_IMM,8'h40,8'h00,8'h2B,8'h40,8'h21);
    alu(OP_XOR,8'hAA,8'hAA,8'h21,8'h00,8'h23);
    alu(OP_INVERT,8'h55,8'h00,8'h20,8'hAA,8'h35);
    alu(OP_ARITH_INVERSE,8'h80,8'h00,8'h00,8'h80,8'h0D);
    alu(OP_ARITH_INVERSE,8'h00,8'h00,8'h21,8'h00,8'h02);
    alu(OP_SET_BITS,8'h01,8'h80,8'h00,8'h81,8'h14);
    alu(OP_CLEAR_BITS,8'h0F,8'h0F,8'h21,8'h00,8'h23);
    alu(OP_INC,8'h7F,8'h00,8'h01,8'h80,8'h0D);
    alu(OP_MINUS_ONE,8'h80,8'h00,8'h01,8'h7F,8'h19);
    alu(OP_ZERO_MINUS_TEST,8'h80,8'h00,8'h08,8'h80,8'h14);
    alu(OP_ZERO_REGISTER,8'h5A,8'h00,8'h1C,8'h00,8'h02);
    alu(OP_ALL_ONES,8'h00,8'h00,8'h2B,8'hFF,8'h2B);
    alu(OP_COMPARE,8'h01,8'h02,8'h00,8'h00,8'h35);
    alu(OP_COMPARE_CARRY,8'h05,8'h05,8'h01,8'h00,8'h35);
    alu(OP_COMPARE_IMM,8'h10,8'h10,8'h21,8'h00,8'h02);
    q = base(OP_ADD_IMM_WORD);
    q.a = 8'hFF;
    q.b = 8'h7F;
    q.imm = 8'h01;
    go(8'h20, 3'h2, 8'h2C);
    chk("pair", 16'h8000, {res.res_hi, res.res_lo});
    q.op = OP_SUBTRACT_IMM_WORD;
    q.a = 8'h00;
    q.b = 8'h00;
    dp = 1'h1;
    go(8'h00, 3'h2, 8'h15);
    dp = 1'h0;
    chk("pair", 16'hFFFF, {res.res_hi, res.res_lo});
    chk("wr_word", 16'h0001, {15'h0, res.wr_word});
    reg_wr(OFS_STATUS, 8'hFF);
    reg_rd(OFS_STATUS, v);
    chk("status", 16'h0004, {8'h00, v});
    q = base(OP_REL_JUMP);
    q.offset = 12'h800;
    flow(8'h00, 3'h2, 16'hF901);
    q = base(OP_IND_JUMP);
    q.ptr = 16'h1234;
    flow(8'h3F, 3'h2, 16'h1234);
    q = base(OP_REL_SUBCALL);
    q.offset = 12'h7FF;
    flow(8'h00, 3'h3, 16'h0900);
    q = base(OP_IND_SUBCALL);
    q.ptr = 16'h4321;
    flow(8'h00, 3'h3, 16'h4321);
    q = base(OP_SUB_EXIT);
    q.stack_pc = 16'h0ABC;
    flow(8'h01, 3'h4, 16'h0ABC);
    q = base(OP_INT_EXIT);
    q.stack_pc = 16'h0055;
    flow(8'h00, 3'h4, 16'h0055);
    skp(OP_EQUAL_SKIP,8'h33,3'h0,1'h0,3'h2,16'h0102);
    skp(OP_EQUAL_SKIP,8'h33,3'h0,1'h1,3'h3,16'h0103);
    skp(OP_EQUAL_SKIP,8'h34,3'h0,1'h1,3'h1,16'h0101);
    skp(OP_SKIP_REG_CLR,8'hFE,3'h0,1'h0,3'h2,16'h0102);
    skp(OP_SKIP_REG_CLR,8'h01,3'h0,1'h1,3'h1,16'h0101);
    skp(OP_SKIP_REG_SET,8'h80,3'h7,1'h1,3'h3,16'h0103);
    skp(OP_SKIP_IO_CLR,8'hF7,3'h3,1'h0,3'h2,16'h0102);
    skp(OP_SKIP_IO_SET,8'h08,3'h3,1'h1,3'h3,16'h0103);
    skp(OP_SKIP_IO_SET,8'hF7,3'h3,1'h0,3'h1,16'h0101);
    for (k = 0; k < 8; k++)
    begin
      v = 8'h01 << k;
      q = base(OP_BRANCH_SET);
      q.bit_sel = k[2:0];
      q.offset = 12'h010;
      flow(v, 3'h2, 16'h0111);
      flow(~v, 3'h1, 16'h0101);
      q.op = OP_BRANCH_CLR;
      flow(~v, 3'h2, 16'h0111);
      flow(v, 3'h1, 16'h0101);
    end
    q = base(OP_BRANCH_EQ);
    q.offset = 12'hFFF;
    flow(8'h02, 3'h2, 16'h0100);
    flow(8'hFD, 3'h1, 16'h0101);
    tally_and_finish();
  end

endmodule : testbench
